/* File: design/adchts_top.sv */
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/100ps
`include "adchts_defs.svh"
module adchts_top #(
    parameter int ADDR_W = 8,
    parameter int CONV_TIME_NS = `ADCHTS_CONV_TIME_NS
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic hw_trigger,
    input wire adchts_pkg::adchts_ain_t analog_inputs,
    output logic conversion_end_interrupt,
    output logic converter_powered
);
    import adchts_pkg::*;
    default clocking @(posedge clk);
    endclocking
    default disable iff (srst);

    localparam int CONV_CYCLES =
        (CONV_TIME_NS + `ADCHTS_CLK_PERIOD_NS - 1) / `ADCHTS_CLK_PERIOD_NS;

    generate
        if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr
            $error("Address width must hold the register map.");
        end
    endgenerate

    // Returns {hit, word index}; only the four low words are mapped.
    function automatic logic [2:0] reg_decode(input logic [ADDR_W-1:0] a);
        logic [31:0] wide;
        wide = 32'(a);
        reg_decode = {(wide[31:4] == 28'h0000000), wide[3:2]};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register bus slave.
    logic [ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic [2:0] wdec, rdec;
    logic wr_go, wr_ctrl, wr_chsel;
    assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wdec = reg_decode(awaddr_reg);
    assign rdec = reg_decode(s_axi_araddr);
    assign wr_ctrl = wr_go && wdec[2] && wstrb_reg[0]
        && wdec[1:0] == 2'(`ADCHTS_OFF_CTRL >> 2);
    assign wr_chsel = wr_go && wdec[2] && wstrb_reg[0]
        && wdec[1:0] == 2'(`ADCHTS_OFF_CHSEL >> 2);

    // Address and data are taken in either order and held until the
    // response is accepted, so one write is in flight at a time.
    always_ff @(posedge clk) begin
        if (srst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ADCHTS_RESP_OKAY;
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wdec[2] ? `ADCHTS_RESP_OKAY
                                       : `ADCHTS_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software configuration.
    logic en_reg, wait_reg, scan_reg, seq_reg;
    logic [`ADCHTS_CH_W-1:0] chsel_reg, chsel_new;
    logic w_en, w_start;
    assign w_en = wdata_reg[`ADCHTS_CTRL_EN];
    assign w_start = wdata_reg[`ADCHTS_CTRL_START];
    assign chsel_new = wr_chsel ? wdata_reg[`ADCHTS_CH_W-1:0] : chsel_reg;

    // Mode bits take effect on the cycle after the write.
    always_ff @(posedge clk) begin
        if (srst) begin
            en_reg <= 1'b0;
            wait_reg <= 1'b0;
            scan_reg <= 1'b0;
            seq_reg <= 1'b0;
            chsel_reg <= '0;
        end else begin
            if (wr_ctrl) begin
                en_reg <= w_en;
                wait_reg <= wdata_reg[`ADCHTS_CTRL_WAIT];
                scan_reg <= wdata_reg[`ADCHTS_CTRL_SCAN];
                seq_reg <= wdata_reg[`ADCHTS_CTRL_SEQ];
            end
            if (wr_chsel) begin
                chsel_reg <= chsel_new;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Conversion sequencer.
    adchts_state_t state_reg, state_next;
    logic start_reg, start_next;
    logic [1:0] slot_reg, slot_next;
    logic kick, abort, stop_req, restart_req;
    logic core_done, done_ok;
    adchts_result_t core_result;
    assign stop_req = wr_ctrl && !w_start;
    assign restart_req = hw_trigger || wr_chsel || (wr_ctrl && w_start);
    assign done_ok = core_done && state_reg == ST_CONV && !restart_req
        && !wr_ctrl;
    always_comb begin
        state_next = state_reg;
        start_next = start_reg;
        slot_next = slot_reg;
        kick = 1'b0;
        abort = 1'b0;
        unique case (state_reg)
            ST_STOP: begin
                start_next = 1'b0;
                if (wr_ctrl && w_en) begin
                    state_next = wait_reg ? ST_TRIG_STBY
                                          : ST_CONV_STBY;
                end
            end
            ST_CONV_STBY: begin
                if (wr_ctrl && !w_en) begin
                    state_next = ST_STOP;
                    start_next = 1'b0;
                end else if (wr_ctrl) begin
                    start_next = w_start;
                    if (w_start) begin
                        state_next = ST_TRIG_STBY;
                    end
                end else if (hw_trigger && start_reg) begin
                    state_next = ST_CONV;
                    slot_next = `ADCHTS_FIRST_SLOT;
                    kick = 1'b1;
                end
            end
            ST_TRIG_STBY: begin
                if (wr_ctrl && !w_en) begin
                    state_next = ST_STOP;
                    start_next = 1'b0;
                end else if (wait_reg) begin
                    if (hw_trigger && en_reg) begin
                        state_next = ST_CONV;
                        start_next = 1'b1;
                        slot_next = `ADCHTS_FIRST_SLOT;
                        kick = 1'b1;
                    end
                end else if (stop_req) begin
                    state_next = ST_CONV_STBY;
                    start_next = 1'b0;
                end else if (hw_trigger && start_reg) begin
                    state_next = ST_CONV;
                    slot_next = `ADCHTS_FIRST_SLOT;
                    kick = 1'b1;
                end
            end
            ST_CONV: begin
                if (wr_ctrl && !w_en) begin
                    state_next = ST_STOP;
                    start_next = 1'b0;
                    abort = 1'b1;
                end else if (stop_req) begin
                    start_next = 1'b0;
                    abort = 1'b1;
                    state_next = wait_reg ? ST_TRIG_STBY
                                          : ST_CONV_STBY;
                end else if (restart_req) begin
                    slot_next = `ADCHTS_FIRST_SLOT;
                    abort = 1'b1;
                    kick = 1'b1;
                end else if (core_done) begin
                    if (scan_reg && slot_reg != `ADCHTS_LAST_SLOT) begin
                        slot_next = slot_reg + 2'h1;
                        kick = 1'b1;
                    end else if (seq_reg) begin
                        slot_next = `ADCHTS_FIRST_SLOT;
                        kick = 1'b1;
                    end else if (wait_reg) begin
                        start_next = 1'b0;
                        state_next = ST_TRIG_STBY;
                    end else begin
                        state_next = ST_CONV_STBY;
                    end
                end
            end
        endcase
    end

    // The converter is only powered in wait mode while it converts.
    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= ST_STOP;
            start_reg <= 1'b0;
            slot_reg <= `ADCHTS_FIRST_SLOT;
            converter_powered <= 1'b0;
        end else begin
            state_reg <= state_next;
            start_reg <= start_next;
            slot_reg <= slot_next;
            converter_powered <= state_next == ST_CONV
                || (!wait_reg && state_next != ST_STOP);
        end
    end
    adchts_conv_core #(.CONV_CYCLES(CONV_CYCLES)) adchts_conv_core_inst (
        .clk(clk),
        .srst(srst),
        .kick(kick),
        .abort(abort),
        .ch(scan_reg ? chsel_new + slot_next : chsel_new),
        .ain(analog_inputs),
        .done(core_done),
        .result(core_result)
    );
    ////////////////////////////////////////////////////////////////////////
    // Results and end of conversion.
    adchts_result_t result_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            result_reg <= '0;
            conversion_end_interrupt <= 1'b0;
        end else begin
            conversion_end_interrupt <= done_ok;
            if (done_ok) begin
                result_reg <= core_result;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel.
    logic [31:0] rd_word;

    always_comb begin
        rd_word = 32'h00000000;
        unique case (rdec[1:0])
            2'(`ADCHTS_OFF_CTRL >> 2): begin
                rd_word[`ADCHTS_CTRL_EN] = en_reg;
                rd_word[`ADCHTS_CTRL_START] = start_reg;
                rd_word[`ADCHTS_CTRL_WAIT] = wait_reg;
                rd_word[`ADCHTS_CTRL_SCAN] = scan_reg;
                rd_word[`ADCHTS_CTRL_SEQ] = seq_reg;
            end
            2'(`ADCHTS_OFF_CHSEL >> 2): begin
                rd_word[`ADCHTS_CH_W-1:0] = chsel_reg;
            end
            2'(`ADCHTS_OFF_RESULT >> 2): begin
                rd_word[`ADCHTS_RES_W-1:0] = result_reg.data;
                rd_word[`ADCHTS_RES_CH_LSB +: `ADCHTS_CH_W] = result_reg.ch;
            end
            2'(`ADCHTS_OFF_STATUS >> 2): begin
                rd_word[1:0] = state_reg;
                rd_word[`ADCHTS_ST_SLOT_LSB +: 2] = slot_reg;
                rd_word[`ADCHTS_ST_PWR] = converter_powered;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `ADCHTS_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdec[2] ? rd_word : 32'h00000000;
                s_axi_rresp <= rdec[2] ? `ADCHTS_RESP_OKAY
                                       : `ADCHTS_RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    a_reset_to_stop: assert property (disable iff (1'b0)
        srst |=> state_reg == ST_STOP && !en_reg && !start_reg)
        else $error("Reset did not give the stop state.");
    a_enable_standby: assert property (
        state_reg == ST_STOP && wr_ctrl && w_en && !wait_reg
        |=> state_reg == ST_CONV_STBY && !kick)
        else $error("Enable from stop did not reach standby.");
    a_wait_enable: assert property (
        state_reg == ST_STOP && wr_ctrl && w_en && wait_reg
        |=> state_reg == ST_TRIG_STBY && !start_reg)
        else $error("Wait enable did not reach trigger standby.");
    a_trig_ignored: assert property (
        hw_trigger && !start_reg && !wait_reg && state_reg != ST_CONV
        |-> !kick)
        else $error("Trigger started a conversion with start clear.");
    a_scan_order: assert property (
        done_ok && scan_reg && slot_reg != `ADCHTS_LAST_SLOT
        |=> state_reg == ST_CONV && slot_reg == $past(slot_reg) + 2'h1)
        else $error("Scan did not advance to the next slot.");
    a_result_irq: assert property (
        done_ok |=> conversion_end_interrupt
        && result_reg == $past(core_result) ##1 !conversion_end_interrupt)
        else $error("Finished conversion was not reported once.");
    a_abort_silent: assert property (
        abort |=> !conversion_end_interrupt && $stable(result_reg))
        else $error("Aborted conversion touched the result.");
    a_trig_restart: assert property (
        state_reg == ST_CONV && hw_trigger && !wr_ctrl |-> kick && abort
        ##1 state_reg == ST_CONV && slot_reg == `ADCHTS_FIRST_SLOT)
        else $error("Trigger did not restart the conversion.");
    a_oneshot_stby: assert property (
        done_ok && scan_reg && !seq_reg && !wait_reg
        && slot_reg == `ADCHTS_LAST_SLOT
        |=> state_reg == ST_CONV_STBY && start_reg)
        else $error("Scan one-shot end did not return to standby.");
    a_wait_auto_start: assert property (
        state_reg == ST_TRIG_STBY && wait_reg && hw_trigger && !wr_ctrl
        |=> state_reg == ST_CONV && start_reg && converter_powered)
        else $error("Wait trigger did not start and set start.");
    a_wait_clear: assert property (
        state_reg == ST_CONV && wait_reg && stop_req && w_en
        |=> state_reg == ST_TRIG_STBY && !converter_powered)
        else $error("Wait start clear did not stop the converter.");
    a_enable_clear: assert property (
        state_reg == ST_CONV_STBY && wr_ctrl && !w_en
        |=> state_reg == ST_STOP && !converter_powered)
        else $error("Enable clear in standby did not stop.");
endmodule

/* File: pkg/adchts_defs.svh */
`ifndef ADCHTS_DEFS_SVH
`define ADCHTS_DEFS_SVH
`define ADCHTS_NCH 4
`define ADCHTS_CH_W 2
`define ADCHTS_RES_W 10
`define ADCHTS_LAST_SLOT 2'h3
`define ADCHTS_FIRST_SLOT 2'h0
`define ADCHTS_CLK_PERIOD_NS 25
`define ADCHTS_CONV_TIME_NS 1000
`define ADCHTS_OFF_CTRL 8'h00
`define ADCHTS_OFF_CHSEL 8'h04
`define ADCHTS_OFF_RESULT 8'h08
`define ADCHTS_OFF_STATUS 8'h0C
`define ADCHTS_CTRL_EN 0
`define ADCHTS_CTRL_START 1
`define ADCHTS_CTRL_WAIT 2
`define ADCHTS_CTRL_SCAN 3
`define ADCHTS_CTRL_SEQ 4
`define ADCHTS_RES_CH_LSB 12
`define ADCHTS_ST_SLOT_LSB 4
`define ADCHTS_ST_PWR 8
`define ADCHTS_RESP_OKAY 2'h0
`define ADCHTS_RESP_SLVERR 2'h2
`endif

/* File: pkg/adchts_pkg.sv */
`include "adchts_defs.svh"
package adchts_pkg;
    typedef enum logic [1:0] {
        ST_STOP,
        ST_CONV_STBY,
        ST_TRIG_STBY,
        ST_CONV
    } adchts_state_t;
    typedef logic [`ADCHTS_NCH-1:0][`ADCHTS_RES_W-1:0] adchts_ain_t;
    typedef struct packed {
        logic [`ADCHTS_CH_W-1:0] ch;
        logic [`ADCHTS_RES_W-1:0] data;
    } adchts_result_t;
endpackage

/* File: design/adchts_conv_core.sv */
`timescale 1ns/100ps
`include "adchts_defs.svh"
module adchts_conv_core #(
    parameter int CONV_CYCLES = 40
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic kick,
    input wire logic abort,
    input wire logic [`ADCHTS_CH_W-1:0] ch,
    input wire adchts_pkg::adchts_ain_t ain,
    output logic done,
    output adchts_pkg::adchts_result_t result
);
    import adchts_pkg::*;

    localparam int CNT_W = $clog2(CONV_CYCLES + 1);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(CONV_CYCLES - 1);

    generate
        if (CONV_CYCLES < 2) begin : g_bad_cycles
            $error("Conversion needs at least two cycles.");
        end
    endgenerate

    logic busy_reg;
    logic [CNT_W-1:0] cnt_reg;
    adchts_result_t sample_reg;

    ////////////////////////////////////////////////////////////////////////
    // A kick always restarts, so an abort with a kick discards old data.
    always_ff @(posedge clk) begin
        if (srst) begin
            busy_reg <= 1'b0;
            cnt_reg <= '0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (kick) begin
                busy_reg <= 1'b1;
                cnt_reg <= '0;
            end else if (abort) begin
                busy_reg <= 1'b0;
            end else if (busy_reg) begin
                cnt_reg <= cnt_reg + 1'b1;
                if (cnt_reg == LAST) begin
                    busy_reg <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            sample_reg <= '0;
            result <= '0;
        end else begin
            if (kick) begin
                sample_reg.ch <= ch;
                sample_reg.data <= ain[ch];
            end
            if (busy_reg && !kick && !abort && cnt_reg == LAST) begin
                result <= sample_reg;
            end
        end
    end
endmodule

/* File: dv/adchts_trig_src.sv */
`timescale 1ns/100ps
module adchts_trig_src (
    input wire logic clk,
    input wire logic go,
    output logic hw_trigger,
    output adchts_pkg::adchts_ain_t analog_inputs
);
    import adchts_pkg::*;
    logic go_q;
    ////////////////////////////////////////
    // One pulse per request, one cycle wide, since every high cycle counts.
    always_ff @(posedge clk) begin
        go_q <= go;
        hw_trigger <= go & ~go_q;
    end
    // Distinct levels per input let each result name its source.
    always_comb begin
        for (int n = 0; n < 4; n++) begin
            analog_inputs[n] = 10'h2A0 + 10'(n);
        end
    end
endmodule

/* File: dv/adchts_top_tb.sv */
`timescale 1ns/100ps
`include "adchts_defs.svh"
module adchts_top_tb;
    import adchts_pkg::*;
    logic clk, srst, go, trg, irq, pwr;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [1:0] bresp, rresp;
    adchts_ain_t ain;
    int miscompares, cmp_count, irq_cnt, used;
    ////////////////////////////////////////
    // A short conversion keeps the run brief; twenty cycles per channel.
    adchts_top #(.CONV_TIME_NS(500)) adchts_top_inst (
        .clk(clk), .srst(srst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .hw_trigger(trg), .analog_inputs(ain),
        .conversion_end_interrupt(irq), .converter_powered(pwr)
    );
    adchts_trig_src adchts_trig_src_inst (
        .clk(clk), .go(go), .hw_trigger(trg), .analog_inputs(ain)
    );
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always_ff @(posedge clk) begin
        if (srst) irq_cnt <= 0;
        else if (irq) irq_cnt <= irq_cnt + 1;
    end
    ////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic tmo(input int n);
        if (n >= 400) begin
            $display("[ERR] wait expected answer seen none");
            miscompares++;
            wrap_up();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 400);
        bready <= 1'b0;
        tmo(n);
        chk("bresp", 32'h0, {30'h0, bresp});
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e, input string nm);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 400);
        rready <= 1'b0;
        rd = rdata;
        tmo(n);
        chk("rresp", (a > 8'h0F) ? 32'h2 : 32'h0, {30'h0, rresp});
        chk(nm, e, rd & m);
    endtask
    task automatic trig();
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
    endtask
    // Sixty cycles cover three whole conversions of 20 cycles each, so a stray pulse shows.
    task automatic quiet(input string nm);
        repeat (60) @(posedge clk);
        chk(nm, used, irq_cnt);
    endtask
    task automatic irq_ch(input logic [1:0] c);
        int n;
        n = 0;
        while (irq_cnt == used && n < 400) begin
            @(posedge clk);
            n++;
        end
        tmo(n);
        used++;
        rdc(`ADCHTS_OFF_RESULT, 32'h33FF,
            {18'h0, c, 2'h0, 10'h2A0 + {8'h0, c}}, "result");
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        wrap_up();
    end
    initial begin
        {srst, go, awaddr, araddr, wdata, used} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        srst = 1'b1;
        wstrb = 4'hF;
        miscompares = 0;
        cmp_count = 0;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        rdc(`ADCHTS_OFF_CTRL, 32'h1F, 32'h0, "ctrl");
        rdc(`ADCHTS_OFF_STATUS, 32'h133, 32'h0, "status");
        rdc(8'h40, 32'hFFFFFFFF, 32'h0, "unmapped");
        $display("test reset done");
        wr(`ADCHTS_OFF_CHSEL, 32'h1);
        wr(`ADCHTS_OFF_CTRL, 32'h09);
        rdc(`ADCHTS_OFF_STATUS, 32'h3, 32'h1, "state");
        trig();
        quiet("idle");
        repeat (40) @(posedge clk);
        wr(`ADCHTS_OFF_CTRL, 32'h0B);
        rdc(`ADCHTS_OFF_STATUS, 32'h3, 32'h2, "state");
        quiet("armed");
        trig();
        for (int k = 1; k < 5; k++) begin
            irq_ch(2'(k));
        end
        quiet("scan end");
        rdc(`ADCHTS_OFF_CTRL, 32'h2, 32'h2, "start");
        rdc(`ADCHTS_OFF_STATUS, 32'h3, 32'h1, "state");
        trig();
        irq_ch(2'h1);
        trig();
        irq_ch(2'h1);
        wr(`ADCHTS_OFF_CHSEL, 32'h2);
        irq_ch(2'h2);
        wr(`ADCHTS_OFF_CTRL, 32'h0B);
        irq_ch(2'h2);
        wr(`ADCHTS_OFF_CTRL, 32'h09);
        quiet("cleared");
        rdc(`ADCHTS_OFF_STATUS, 32'h103, 32'h101, "state");
        wr(`ADCHTS_OFF_CTRL, 32'h0);
        rdc(`ADCHTS_OFF_STATUS, 32'h3, 32'h0, "state");
        $display("test no-wait scan done");
        wr(`ADCHTS_OFF_CHSEL, 32'h3);
        wr(`ADCHTS_OFF_CTRL, 32'h14);
        trig();
        quiet("off");
        rdc(`ADCHTS_OFF_STATUS, 32'h3, 32'h0, "state");
        wr(`ADCHTS_OFF_CTRL, 32'h15);
        rdc(`ADCHTS_OFF_STATUS, 32'h3, 32'h2, "state");
        trig();
        rdc(`ADCHTS_OFF_CTRL, 32'h2, 32'h2, "start");
        irq_ch(2'h3);
        irq_ch(2'h3);
        trig();
        irq_ch(2'h3);
        wr(`ADCHTS_OFF_CTRL, 32'h17);
        irq_ch(2'h3);
        wr(`ADCHTS_OFF_CTRL, 32'h15);
        quiet("aborted");
        rdc(`ADCHTS_OFF_STATUS, 32'h103, 32'h2, "state");
        chk("powered", 32'h0, {31'h0, pwr});
        $display("test wait select done");
        wrap_up();
    end
endmodule
